// ==== common/rtsg_defines.vh ====
// Constants for the reference tick swallow generator.
// Assumes one 100 MHz system clock and an APB register port.
//
// Notes on behaviour
// - Idle moves to swallow when held dummy select is set, else stays.
// - Swallow moves to pass-rise on a reference rising edge, else stays.
// - Pass-rise moves to pass-fall on a reference rising edge, else stays.
// - Pass-fall returns to idle on a reference falling edge, else stays.
// - First rising edge after dummy select gives no output pulse.
// - Swallowed edge made up on next rise and following fall; idle passes rises.
// - Skip state machine runs on the system clock.
// - Besides leaving idle, state changes only on detected reference edges.
// - Test pulse follows the same conditions but ignores every inhibit.
// - Dummy select captured at chip select edge when select bits read 10110.
// - Dummy select cleared in pass-fall on a detected falling edge.
// - Held dummy select follows while timer phase high, holds while low; cleared on the pass-fall falling edge in either phase.
// - Held inhibit is OR of two active-low and one active-high input.
// - Count pulses blocked during timer reads and while sync is at stop.
// - Reference sampled at timer phase fall; compare with one-clock delayed copy.
// - Skip states coded 00 idle, 01 swallow, 11 pass-rise, 10 pass-fall.
// - Count pulses spaced no closer than 1 us; closer ones are not blocked, only flagged as a sticky error.
`ifndef RTSG_DEFINES_VH
`define RTSG_DEFINES_VH

// ****************************************************************
// Skip state codes
// ****************************************************************
`define RTSG_ST_IDLE 2'h0
`define RTSG_ST_SWALLOW 2'h1
`define RTSG_ST_PASS_RISE 2'h3
`define RTSG_ST_PASS_FALL 2'h2

// ****************************************************************
// Select pattern and register map
// ****************************************************************
`define RTSG_DUMMY_SEL 5'h16
`define RTSG_OFS_CTRL 12'h000
`define RTSG_OFS_STATUS 12'h004
`define RTSG_OFS_TICKS 12'h008
`define RTSG_OFS_SWALLOWS 12'h00C
`define RTSG_CTRL_INH_BIT 0
`define RTSG_CTRL_ARM_BIT 1
`define RTSG_STAT_ERR_BIT 5
`define RTSG_CTRL_RESET 1'h0

// ****************************************************************
// Timing
// ****************************************************************
`define RTSG_CLK_MHZ 100
`define RTSG_MIN_SPACE_US 1
`define RTSG_MIN_SPACE_CYC (`RTSG_MIN_SPACE_US * `RTSG_CLK_MHZ)
`define RTSG_SPACE_W 8
`define RTSG_MIN_SPACE_CNT 8'h64

`endif

// ==== hdl/rtsg_top.v ====
// Reference tick swallow generator: turns the reference clock into
// count pulses for a parallel timer chip, swallowing one edge per read.
// Assumes all pins synchronous to ref_clk and an APB master for software.
`timescale 1ns/10ps
`include "rtsg_defines.vh"

module rtsg_top (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    // Timer chip host side
    input wire chipSelN,
    input wire [5:1] regSelectBits,
    input wire timerClockPhase,
    // Reference clock and inhibits
    input wire refClock,
    input wire inhibitAN,
    input wire inhibitBN,
    input wire inhibitC,
    input wire syncRun,
    // Pulse outputs
    output wire countTick,
    output wire testTick,
    output wire [1:0] skipState
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Register index from an APB byte address
    function [1:0] regIndex;
        input [11:0] addr;
        begin
            regIndex = addr[3:2];
        end
    endfunction

    // Address lies inside the four-word map
    function isMapped;
        input [11:0] addr;
        begin
            isMapped = (addr[11:4] == 8'h00) && (addr[1:0] == 2'h0);
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg phasePrev_r;
    reg csPrev_r;
    reg refSample_r;
    reg refDelay_r;
    reg dummySel_r;
    reg dummyHeld_r;
    reg inhHeld_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg countTick_r;
    reg testTick_r;
    reg swInhibit_r;
    reg spaceErr_r;
    reg [`RTSG_SPACE_W-1:0] spaceCnt_r;
    reg [31:0] tickCnt_r;
    reg [31:0] swallowCnt_r;
    reg [31:0] prdata_r;
    reg [31:0] rdMux;
    wire phaseFall;
    wire csEdge;
    wire refRise;
    wire refFall;
    wire passEdge;
    wire inhAny;
    wire wrCycle;
    wire armPulse;
    wire dummyClear;
    wire spaceShort;

    // ****************************************************************
    // Edge detection
    // ****************************************************************

    // Phase and chip select history
    always @(posedge ref_clk) begin
        if (rst) begin
            phasePrev_r <= 1'b0;
            csPrev_r <= 1'b1;
        end else begin
            phasePrev_r <= timerClockPhase;
            csPrev_r <= chipSelN;
        end
    end

    assign phaseFall = phasePrev_r & ~timerClockPhase;
    assign csEdge = csPrev_r & ~chipSelN; // Leading edge of select

    // Reference sample at phase fall, copy one clock later
    always @(posedge ref_clk) begin
        if (rst) begin
            refSample_r <= 1'b0;
            refDelay_r <= 1'b0;
        end else begin
            if (phaseFall) begin
                refSample_r <= refClock;
            end
            refDelay_r <= refSample_r;
        end
    end

    // Each edge flag holds one clock only, since the copy catches up
    assign refRise = refSample_r & ~refDelay_r;
    assign refFall = ~refSample_r & refDelay_r;

    // ****************************************************************
    // Dummy select and inhibit holding
    // ****************************************************************
    assign wrCycle = psel & penable & pwrite & isMapped(paddr);
    assign armPulse = wrCycle && (regIndex(paddr) == 2'h0) && pwdata[`RTSG_CTRL_ARM_BIT];
    assign dummyClear = (state_r == `RTSG_ST_PASS_FALL) & refFall;

    // Captured at select edge; a fresh select beats the clear
    always @(posedge ref_clk) begin
        if (rst) begin
            dummySel_r <= 1'b0;
        end else if ((csEdge && regSelectBits == `RTSG_DUMMY_SEL) || armPulse) begin
            dummySel_r <= 1'b1;
        end else if (dummyClear) begin
            dummySel_r <= 1'b0;
        end
    end

    // Inhibit sources; sync at stop also blocks counting
    assign inhAny = ~inhibitAN | ~inhibitBN | inhibitC;

    // Transparent while phase high, frozen while low; the held select is
    // dropped with the flag, else a stale copy re-arms idle a cycle later
    always @(posedge ref_clk) begin
        if (rst) begin
            dummyHeld_r <= 1'b0;
            inhHeld_r <= 1'b0;
        end else begin
            if (dummyClear) begin
                dummyHeld_r <= 1'b0;
            end else if (timerClockPhase) begin
                dummyHeld_r <= dummySel_r;
            end
            if (timerClockPhase) begin
                inhHeld_r <= inhAny;
            end
        end
    end

    // ****************************************************************
    // Skip state machine
    // ****************************************************************

    // Next state; only edges move it once idle is left
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `RTSG_ST_IDLE: begin
                if (dummyHeld_r) begin
                    state_nxt = `RTSG_ST_SWALLOW;
                end
            end
            `RTSG_ST_SWALLOW: begin
                if (refRise) begin
                    state_nxt = `RTSG_ST_PASS_RISE;
                end
            end
            `RTSG_ST_PASS_RISE: begin
                if (refRise) begin
                    state_nxt = `RTSG_ST_PASS_FALL;
                end
            end
            `RTSG_ST_PASS_FALL: begin
                if (refFall) begin
                    state_nxt = `RTSG_ST_IDLE;
                end
            end
            default: begin
                state_nxt = `RTSG_ST_IDLE;
            end
        endcase
    end

    // State register on the system clock
    always @(posedge ref_clk) begin
        if (rst) begin
            state_r <= `RTSG_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // Pulse generation
    // ****************************************************************

    // Swallow state passes nothing, so the first rise is dropped
    assign passEdge = ((state_r == `RTSG_ST_IDLE) & refRise)
        | ((state_r == `RTSG_ST_PASS_RISE) & refRise)
        | ((state_r == `RTSG_ST_PASS_FALL) & refFall);

    // Registered pulses, one clock each
    always @(posedge ref_clk) begin
        if (rst) begin
            countTick_r <= 1'b0;
            testTick_r <= 1'b0;
        end else begin
            countTick_r <= passEdge & ~inhHeld_r & ~swInhibit_r & syncRun;
            testTick_r <= passEdge;
        end
    end

    assign countTick = countTick_r;
    assign testTick = testTick_r;
    assign skipState = state_r;

    // ****************************************************************
    // Pulse spacing watch
    // ****************************************************************

    // Cycles since last count pulse, saturating at the minimum
    always @(posedge ref_clk) begin
        if (rst) begin
            spaceCnt_r <= `RTSG_MIN_SPACE_CNT;
        end else if (countTick_r) begin
            spaceCnt_r <= {{(`RTSG_SPACE_W-1){1'b0}}, 1'b1};
        end else if (spaceCnt_r < `RTSG_MIN_SPACE_CNT) begin
            spaceCnt_r <= spaceCnt_r + 1'b1;
        end
    end

    // Reference far slower than 1 us in practice; this only flags faults
    assign spaceShort = countTick_r && (spaceCnt_r < `RTSG_MIN_SPACE_CNT);

    // ****************************************************************
    // Software state
    // ****************************************************************

    // Control, sticky spacing error, event counters
    always @(posedge ref_clk) begin
        if (rst) begin
            swInhibit_r <= `RTSG_CTRL_RESET;
            spaceErr_r <= 1'b0;
            tickCnt_r <= 32'h00000000;
            swallowCnt_r <= 32'h00000000;
        end else begin
            if (wrCycle && regIndex(paddr) == 2'h0) begin
                swInhibit_r <= pwdata[`RTSG_CTRL_INH_BIT];
            end
            // Set wins over write-one clear
            if (spaceShort) begin
                spaceErr_r <= 1'b1;
            end else if (wrCycle && regIndex(paddr) == 2'h1 && pwdata[`RTSG_STAT_ERR_BIT]) begin
                spaceErr_r <= 1'b0;
            end
            // Count wins over a clearing write
            if (countTick_r) begin
                tickCnt_r <= tickCnt_r + 32'h00000001;
            end else if (wrCycle && regIndex(paddr) == 2'h2) begin
                tickCnt_r <= 32'h00000000;
            end
            if (state_r == `RTSG_ST_SWALLOW && refRise) begin
                swallowCnt_r <= swallowCnt_r + 32'h00000001;
            end else if (wrCycle && regIndex(paddr) == 2'h3) begin
                swallowCnt_r <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // APB read path
    // ****************************************************************

    // Read mux, unmapped reads give zero
    always @* begin
        rdMux = 32'h00000000;
        if (isMapped(paddr)) begin
            case (regIndex(paddr))
                2'h0: rdMux = {31'h00000000, swInhibit_r};
                2'h1: rdMux = {26'h0000000, spaceErr_r, inhHeld_r, dummyHeld_r,
                    dummySel_r, state_r};
                2'h2: rdMux = tickCnt_r;
                default: rdMux = swallowCnt_r;
            endcase
        end
    end

    // Data captured in setup so it comes from a flop in access
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rdMux;
        end
    end

    // Zero wait states
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~isMapped(paddr);
    assign prdata = prdata_r;

endmodule

// ==== tb/rtsg_checker.sv ====
// Pin assertions for the tick generator.
// Assumes a bind into rtsg_top and one clock.
`timescale 1ns/10ps
`include "rtsg_defines.vh"
module rtsg_checker (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Watched pins
    input wire inhibitC,
    input wire syncRun,
    input wire countTick,
    input wire testTick,
    input wire [1:0] skipState
);
    // ************
    // Skip walk
    // ************
    default clocking cb @(posedge ref_clk);
    endclocking
    // A state left for another one
    sequence s_leave(logic [1:0] st);
        skipState == st ##1 skipState != st;
    endsequence
    a_reset_quiet: assert property (rst |=> skipState == 2'h0 && !countTick && !testTick)
        else $error("not quiet after reset");
    a_idle_exit: assert property (disable iff (rst)
        s_leave(`RTSG_ST_IDLE) |-> skipState == `RTSG_ST_SWALLOW)
        else $error("bad exit from idle");
    a_swallow_exit: assert property (disable iff (rst)
        s_leave(`RTSG_ST_SWALLOW) |-> skipState == `RTSG_ST_PASS_RISE && !testTick)
        else $error("bad exit from swallow");
    a_rise_exit: assert property (disable iff (rst)
        s_leave(`RTSG_ST_PASS_RISE) |-> skipState == `RTSG_ST_PASS_FALL && testTick)
        else $error("bad exit from pass-rise");
    a_fall_exit: assert property (disable iff (rst)
        s_leave(`RTSG_ST_PASS_FALL) |-> skipState == `RTSG_ST_IDLE && testTick)
        else $error("bad exit from pass-fall");
    a_tick_single: assert property (disable iff (rst) testTick |=> !testTick)
        else $error("tick longer than a cycle");
    a_count_subset: assert property (disable iff (rst) countTick |-> testTick)
        else $error("count tick without test tick");
    a_stop_blocks: assert property (disable iff (rst) countTick |-> $past(syncRun))
        else $error("count tick at stop");
    a_inhibit_blocks: assert property (disable iff (rst) inhibitC [*8] |=> !countTick)
        else $error("count tick while inhibited");
endmodule
bind rtsg_top rtsg_checker u_chk (.ref_clk(ref_clk), .rst(rst), .inhibitC(inhibitC),
    .syncRun(syncRun), .countTick(countTick), .testTick(testTick), .skipState(skipState));

// ==== tb/rtsg_far_model.sv ====
// Far side: reference clock, timer phase, timer counter.
// Assumes the bench drives rst and syncRun.
`timescale 1ns/10ps
module rtsg_far_model #(
    parameter int HALF = 120
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Block side
    input wire countTick,
    input wire syncRun,
    output logic refClock,
    output logic timerClockPhase,
    output logic [23:0] expTime,
    output logic spaceErr
);
    // ************
    // Clocks
    // ************
    int n = 0;
    int gap = 1000;
    initial begin
        refClock = 1'b0;
        timerClockPhase = 1'b0;
        spaceErr = 1'b0;
        expTime = 24'h000000;
    end
    // Free reference; half period above the 100-cycle spacing
    always @(posedge ref_clk) begin
        n <= (n == HALF - 1) ? 0 : n + 1;
        timerClockPhase <= n[2];
        if (n == HALF - 1) begin
            refClock <= !refClock;
        end
        gap <= countTick ? 0 : gap + 1;
        if (countTick && gap < 99) begin
            spaceErr <= 1'b1;
        end
    end
    // Time held at zero on stop, one count a tick on run
    always @(posedge ref_clk) begin
        if (rst || !syncRun) begin
            expTime <= 24'h000000;
        end else if (countTick) begin
            expTime <= expTime + 24'h000001;
        end
    end
endmodule

// ==== tb/ref_tick_swallow_gen_tb.sv ====
// Self-checking bench for the tick generator.
// Assumes rtsg_top, the far model and the bound checker.
`timescale 1ns/10ps
`include "rtsg_defines.vh"
module ref_tick_swallow_gen_tb;
    // ************
    // Pins
    // ************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic chipSelN = 1'b1;
    logic [5:1] regSelectBits = 5'h00;
    logic inhibitAN = 1'b1;
    logic inhibitBN = 1'b1;
    logic inhibitC = 1'b0;
    logic syncRun = 1'b1;
    wire pready, pslverr, countTick, testTick, timerClockPhase, refClock, spaceErr;
    wire [31:0] prdata;
    wire [1:0] skipState;
    wire [23:0] expTime;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 74955;
    int nT = 0;
    int nC = 0;
    logic [31:0] rd;
    logic er;
    rtsg_top uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .chipSelN, .regSelectBits, .timerClockPhase, .refClock,
        .inhibitAN, .inhibitBN, .inhibitC, .syncRun, .countTick, .testTick, .skipState);
    rtsg_far_model #(.HALF(120)) far (.ref_clk, .rst, .countTick, .syncRun, .refClock,
        .timerClockPhase, .expTime, .spaceErr);
    // Clock
    always #5 ref_clk = !ref_clk;
    // Tick tallies and hang guard
    always @(posedge ref_clk) begin
        nT <= nT + testTick;
        nC <= nC + countTick;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // APB transfer, entered just after a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never re-raises psel in the same step
        @(posedge ref_clk);
    endtask
    task wait_ref(input logic lv);
        @(posedge ref_clk);
        while (refClock !== lv) @(posedge ref_clk);
    endtask
    // ************
    // Scenarios
    // ************
    initial begin
        int m;
        int e1;
        int e2;
        int eT;
        int eC;
        int nD;
        int x;
        int pm;
        logic dm;
        logic ar;
        logic sl;
        logic [4:0] s;
        eT = 0;
        eC = 0;
        nD = 0;
        pm = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(32'(skipState), `RTSG_ST_IDLE);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(er), 1);
        chk(rd, 0);
        apb(1'b1, `RTSG_OFS_TICKS, 32'h0);
        for (int i = 0; i < 14; i++) begin
            // Mode 0 free, 1-3 pin inhibits, 4 stop, 5 software inhibit
            m = (i == 0) ? 4 : (i == 1) ? 0 : $unsigned($random(seed)) % 6;
            dm = (i == 1) || ($random(seed) % 2 != 0);
            // Some dummy selects come from the software arm bit instead
            ar = dm && (i > 1) && ($random(seed) % 2 != 0);
            sl = dm && !ar;
            s = sl ? `RTSG_DUMMY_SEL : 5'($random(seed));
            if (!sl && s == `RTSG_DUMMY_SEL) s = 5'h17;
            // Idle rise before the window counts under the previous mode's pins; a mode 5 software inhibit is already cleared
            x = (pm == 0 || pm == 5) ? 1 : 0;
            wait_ref(1'b1);
            wait_ref(1'b0);
            inhibitAN <= (m != 1);
            inhibitBN <= (m != 2);
            inhibitC <= (m == 3);
            syncRun <= (m != 4);
            regSelectBits <= s;
            if (m == 5 || ar) apb(1'b1, `RTSG_OFS_CTRL, {30'h0, ar, m == 5});
            e1 = nT;
            e2 = nC;
            chipSelN <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chipSelN <= 1'b1;
            wait_ref(1'b1);
            repeat (20) @(posedge ref_clk);
            chk(32'(skipState), dm ? `RTSG_ST_PASS_RISE : `RTSG_ST_IDLE);
            wait_ref(1'b0);
            wait_ref(1'b1);
            repeat (20) @(posedge ref_clk);
            chk(nT - e1, dm ? 1 : 2);
            chk(nC - e2, (m != 0) ? 0 : (dm ? 1 : 2));
            wait_ref(1'b0);
            repeat (20) @(posedge ref_clk);
            chk(nT - e1, 2);
            chk(32'(skipState), `RTSG_ST_IDLE);
            eC += x + ((m == 0) ? 2 : 0);
            eT = (m == 4) ? 0 : eT + x + ((m == 0) ? 2 : 0);
            chk(32'(expTime), eT);
            if (m == 5) apb(1'b1, `RTSG_OFS_CTRL, 32'h0);
            if (dm) nD++;
            pm = m;
        end
        apb(1'b0, `RTSG_OFS_TICKS, 32'h0);
        chk(rd, eC);
        apb(1'b0, `RTSG_OFS_SWALLOWS, 32'h0);
        chk(rd, nD);
        apb(1'b0, `RTSG_OFS_STATUS, 32'h0);
        chk(rd, (m >= 1 && m <= 3) ? 32'h10 : 32'h0);
        chk(32'(spaceErr), 0);
        stop_test();
    end
endmodule
